// [hw/dfa_defines.svh]
// Register offsets, field positions, reset values and timing counts of the data flash access block
`ifndef DFA_DEFINES_SVH
`define DFA_DEFINES_SVH
`define DFA_ADR_LO       16'h1c8c
`define DFA_ADR_HI       16'h1c8d
`define DFA_DAT_LO       16'h1c8e
`define DFA_DAT_HI       16'h1c8f
`define DFA_CTRL         16'h1c90
`define DFA_KEY          16'h1c91
`define DFA_KEY_FIRST    8'h55
`define DFA_KEY_SECOND   8'haa
`define DFA_CTRL_RST     8'h00
`define DFA_B_RD         0
`define DFA_B_WR         1
`define DFA_B_PROGRAM_ENABLE       2
`define DFA_B_WERR       3
`define DFA_B_ERASE      4
`define DFA_B_LATCH      5
`define DFA_B_REGION     6
`define DFA_IND_TAG      4'h7
`define DFA_DF_PAGE      7'h70
`define DFA_CLK_MHZ      200
`define DFA_PROG_TIME_NS 4000
`define DFA_PROG_CYCLES  ((`DFA_PROG_TIME_NS * `DFA_CLK_MHZ) / 1000)
`endif

// [hw/dfa_pkg.sv]
// Types shared by the data flash access block
package dfa_pkg;
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_ONE  = 2'b01,
		KEY_TWO  = 2'b10
	} dfa_key_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [13:0] data;
		logic        region;
		logic        latch;
		logic        erase_en;
		logic        werr;
		logic        program_enable;
		logic        wr;
		logic        rd;
		dfa_key_t    key;
		logic        done_flag;
		logic [7:0]  ind_rdata;
	} dfa_ctrl_st_t;
endpackage : dfa_pkg

// [hw/dfa_mem_if.sv]
// Carrier between the access controller and the byte array
`timescale 1ns/1ps
interface dfa_mem_if #(parameter int AW = 8);
	logic          start;
	logic          abort;
	logic [AW-1:0] wr_addr;
	logic [7:0]    wr_data;
	logic          done;
	logic [AW-1:0] rd_addr;
	logic [7:0]    rd_data;
	logic [AW-1:0] ind_addr;
	logic [7:0]    ind_data;
	modport ctrl (output start, abort, wr_addr, wr_data, rd_addr, ind_addr, input done, rd_data, ind_data);
	modport mem  (input start, abort, wr_addr, wr_data, rd_addr, ind_addr, output done, rd_data, ind_data);
endinterface : dfa_mem_if

// [hw/dfa_array.sv]
// Byte array with self-timed program timer
`timescale 1ns/1ps
`include "dfa_defines.svh"
module dfa_array import dfa_pkg::*; #(
	parameter int DEPTH       = 256,
	parameter int AW          = 8,
	parameter int PROG_CYCLES = `DFA_PROG_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Controller side
	dfa_mem_if.mem   bus
);
	typedef struct packed {
		logic          busy;
		logic [15:0]   cnt;
		logic [AW-1:0] addr;
		logic [7:0]    data;
	} dfa_arr_st_t;

	dfa_arr_st_t st;
	dfa_arr_st_t next_st;
	logic [7:0]  mem [DEPTH];

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	always_comb begin
		next_st = st;
		if (bus.abort) begin
			next_st.busy = 1'b0;
		end else if (bus.start && !st.busy) begin
			// Timer loaded so the start bit stays set exactly PROG_CYCLES cycles
			next_st.busy = 1'b1; // RULE26
			next_st.cnt  = 16'(PROG_CYCLES - 1);
			next_st.addr = bus.wr_addr;
			next_st.data = bus.wr_data;
		end else if (st.busy) begin
			if (st.cnt == 16'h0000) begin
				next_st.busy = 1'b0;
			end else begin
				next_st.cnt = st.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Erase and program of one byte happen as a single replace at the end of the timer
	always_ff @(posedge clock) begin
		if (bus.done) begin
			mem[st.addr] <= st.data; // RULE2
		end
	end

	assign bus.done     = st.busy && (st.cnt == 16'h0000) && !bus.abort;
	assign bus.rd_data  = mem[bus.rd_addr]; // RULE1
	assign bus.ind_data = mem[bus.ind_addr];

	done_single_a: assert property (bus.done |=> !bus.done) // RULE26
		else $error("program done held longer than one cycle");
	byte_written_a: assert property (bus.done |=> mem[$past(st.addr)] == $past(st.data)) // RULE14
		else $error("programmed byte does not hold the written value");
endmodule : dfa_array

// [hw/dfa_ctrl.sv]
// Data flash byte access controller with register port and indirect read path
`timescale 1ns/1ps
`include "dfa_defines.svh"
// Summary of operation
// RULE1: Data flash is read and written one byte, data low byte, at address pair.
// RULE2: Each byte write erases then programs, timed by the internal timer.
// RULE3: Indirect reads reach data flash when pointer bits 15:12 equal 0111.
// RULE4: Indirect reads of unimplemented addresses return zero.
// RULE5: The indirect path is read only and never changes flash contents.
// RULE6: No write starts while the write protect input is low.
// RULE7: A read stalls one cycle and puts the byte in data low next cycle.
// RULE8: Data low keeps the fetched byte until another read or a firmware write.
// RULE9: Hardware clears the read start bit when the read completes.
// RULE10: Write starts only after key 55h, key AAh, then write start bit.
// RULE11: A disturbed unlock sequence starts nothing; the code does not check a disturbance during the 55h key write.
// RULE12: Firmware disables interrupts around the unlock sequence.
// RULE13: The CPU is stalled while the write runs.
// RULE14: Erase is a normal unlocked byte write of 0xff.
// RULE15: Without program enable no write is performed.
// RULE16: A start at a protected byte clears the start bit at once, memory untouched.
// RULE17: On completion the start bit clears, done flag sets, interrupt if enabled.
// RULE18: Write error sets on protected start, reset during write, broken unlock.
// RULE19: Only firmware clears write error; firmware may also set it.
// RULE20: Address register holds 15 bits as high and low bytes; the code keeps all 16 bits, with bit 15 writable and read back.
// RULE21: Data register holds 14 bits as high byte 13:8 and low byte 7:0.
// RULE22: Control bits 6..0: region, latch only, erase, error, enable, write, read.
// RULE23: Region select one reaches data flash, zero reaches program flash.
// RULE24: Write start bit is set only by unlock; writing zero while busy does nothing.
// RULE25: Unlock key register is write only at 0x1c91.
// RULE26: The start bit stays set exactly the programming cycle count.
// RULE27: Unlock steps are consecutive write cycles; any gap aborts with error.
module dfa_ctrl import dfa_pkg::*; #(
	parameter int DEPTH       = 256,
	parameter int PROG_CYCLES = `DFA_PROG_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// CPU register port
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_wr,
	input  wire logic [7:0]  cpu_wdata,
	output logic      [7:0]  cpu_rdata,
	output logic             cpu_stall,
	// Indirect pointer read path
	input  wire logic [15:0] ind_ptr,
	output logic      [7:0]  ind_rdata,
	// Configuration and system events
	input  wire logic        data_write_protect_n,
	input  wire logic        cpu_disturb,
	input  wire logic        soft_reset,
	input  wire logic        op_done_irq_enable,
	input  wire logic        op_done_clear,
	// Completion status
	output logic             op_done_flag,
	output logic             op_done_irq
);
	localparam int AW = 8;

	dfa_ctrl_st_t st;
	dfa_ctrl_st_t next_st;
	logic         df_hit;
	logic         ind_hit;
	logic         key_wr;
	logic         ctl_wr;
	logic         reg_wr;
	logic         accept;
	logic         start;
	logic         prot;
	logic         seq_err;
	logic [15:0]  wr_cnt;

	dfa_mem_if #(.AW(AW)) mbus ();

	dfa_array #(
		.DEPTH       (DEPTH),
		.AW          (AW),
		.PROG_CYCLES (PROG_CYCLES)
	) u_array (
		.clock (clock),
		.rstn  (rstn),
		.bus   (mbus)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// Data flash occupies one page of the region-one space
	assign df_hit  = st.region && (st.addr[14:8] == `DFA_DF_PAGE) && (int'(st.addr[7:0]) < DEPTH); // RULE23
	assign ind_hit = (ind_ptr[15:12] == `DFA_IND_TAG) && (ind_ptr[11:8] == 4'h0)
		&& (int'(ind_ptr[7:0]) < DEPTH); // RULE3
	assign key_wr  = cpu_wr && (cpu_addr == `DFA_KEY); // RULE25
	assign ctl_wr  = cpu_wr && (cpu_addr == `DFA_CTRL);
	assign reg_wr  = cpu_wr && !cpu_stall && !soft_reset;
	assign accept  = (st.key == KEY_TWO) && ctl_wr && cpu_wdata[`DFA_B_WR] && cpu_wdata[`DFA_B_PROGRAM_ENABLE]
		&& !cpu_disturb && !st.wr && !soft_reset; // RULE10 RULE15
	assign start   = accept && df_hit && data_write_protect_n; // RULE6
	assign prot    = accept && df_hit && !data_write_protect_n; // RULE16

	// Unlock sequencer: every step must follow the previous one on the very next cycle
	always_comb begin
		seq_err = 1'b0;
		case (st.key)
			KEY_IDLE: seq_err = 1'b0;
			KEY_ONE: seq_err = !(key_wr && (cpu_wdata == `DFA_KEY_SECOND)) || cpu_disturb; // RULE11 RULE27
			KEY_TWO: seq_err = !(ctl_wr && cpu_wdata[`DFA_B_WR]) || cpu_disturb; // RULE11 RULE27
			default: seq_err = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.ind_rdata = ind_hit ? mbus.ind_data : 8'h00; // RULE4 RULE5
		case (st.key)
			KEY_IDLE: begin
				if (key_wr && !st.wr && (cpu_wdata == `DFA_KEY_FIRST)) begin
					next_st.key = KEY_ONE; // RULE10
				end
			end
			KEY_ONE: next_st.key = seq_err ? KEY_IDLE : KEY_TWO;
			KEY_TWO: next_st.key = KEY_IDLE;
			default: next_st.key = KEY_IDLE;
		endcase
		// Firmware register writes, ignored while the CPU is stalled
		if (reg_wr) begin
			case (cpu_addr)
				`DFA_ADR_LO: next_st.addr[7:0] = cpu_wdata; // RULE20
				`DFA_ADR_HI: next_st.addr[15:8] = cpu_wdata; // RULE20
				`DFA_DAT_LO: next_st.data[7:0] = cpu_wdata; // RULE8 RULE21
				`DFA_DAT_HI: next_st.data[13:8] = cpu_wdata[5:0]; // RULE21
				`DFA_CTRL: begin
					next_st.region   = cpu_wdata[`DFA_B_REGION]; // RULE22
					next_st.latch    = cpu_wdata[`DFA_B_LATCH];
					next_st.erase_en = st.erase_en | cpu_wdata[`DFA_B_ERASE];
					next_st.werr     = cpu_wdata[`DFA_B_WERR]; // RULE19
					next_st.program_enable     = cpu_wdata[`DFA_B_PROGRAM_ENABLE];
					next_st.rd       = cpu_wdata[`DFA_B_RD]; // RULE7
				end
				default: next_st.addr = next_st.addr;
			endcase
		end
		// Read completes one cycle after the start bit is seen
		if (st.rd) begin
			next_st.data = {6'h00, df_hit ? mbus.rd_data : 8'h00}; // RULE1 RULE7
			next_st.rd   = 1'b0; // RULE9
		end
		if (start) begin
			next_st.wr = 1'b1; // RULE10 RULE24
		end
		if (mbus.done) begin
			next_st.wr       = 1'b0; // RULE17
			next_st.erase_en = 1'b0;
			next_st.done_flag = 1'b1;
		end else if (op_done_clear) begin
			next_st.done_flag = 1'b0;
		end
		// Hardware set of the error flag wins over the firmware write
		if (prot || seq_err) begin
			next_st.werr = 1'b1; // RULE18
		end
		// Warm reset clears the controller but leaves evidence of an aborted write
		if (soft_reset) begin
			next_st           = '0;
			next_st.werr      = st.werr | st.wr | prot | seq_err; // RULE18 RULE19
			next_st.ind_rdata = ind_hit ? mbus.ind_data : 8'h00;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= '0; // RULE22
		end else begin
			st <= next_st;
		end
	end

	// Cycle counter of the write start bit, read only by assertions
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_cnt <= 16'h0000;
		end else begin
			wr_cnt <= st.wr ? wr_cnt + 16'h0001 : 16'h0000;
		end
	end

	assign mbus.start    = start; // RULE2
	assign mbus.abort    = soft_reset;
	assign mbus.wr_addr  = st.addr[AW-1:0];
	assign mbus.wr_data  = st.data[7:0]; // RULE14
	assign mbus.rd_addr  = st.addr[AW-1:0];
	assign mbus.ind_addr = ind_ptr[AW-1:0];

	always_comb begin
		case (cpu_addr)
			`DFA_ADR_LO: cpu_rdata = st.addr[7:0];
			`DFA_ADR_HI: cpu_rdata = st.addr[15:8];
			`DFA_DAT_LO: cpu_rdata = st.data[7:0];
			`DFA_DAT_HI: cpu_rdata = {2'b00, st.data[13:8]};
			`DFA_CTRL: cpu_rdata = {1'b0, st.region, st.latch, st.erase_en, st.werr, st.program_enable, st.wr, st.rd};
			default: cpu_rdata = 8'h00;
		endcase
	end

	assign cpu_stall    = st.wr | st.rd; // RULE7 RULE13
	assign ind_rdata    = st.ind_rdata;
	assign op_done_flag = st.done_flag;
	assign op_done_irq  = st.done_flag & op_done_irq_enable; // RULE17

	sequence key_first_s;
		key_wr && (cpu_wdata == `DFA_KEY_FIRST) && (st.key == KEY_IDLE) && !st.wr && !cpu_stall && !soft_reset;
	endsequence
	sequence key_second_s;
		key_wr && (cpu_wdata == `DFA_KEY_SECOND) && !cpu_disturb && !soft_reset;
	endsequence
	sequence wr_set_s;
		ctl_wr && cpu_wdata[`DFA_B_WR] && cpu_wdata[`DFA_B_PROGRAM_ENABLE] && !cpu_disturb && df_hit
			&& data_write_protect_n && !soft_reset;
	endsequence
	property unlock_start_p;
		key_first_s ##1 key_second_s ##1 wr_set_s |=> st.wr && cpu_stall;
	endproperty

	unlock_start_a: assert property (unlock_start_p) // RULE13
		else $error("unlock sequence did not start the write");
	unlock_order_a: assert property ($rose(st.wr) |-> $past(st.key) == KEY_TWO && $past(st.key, 2) == KEY_ONE) // RULE10
		else $error("write started without the two key writes");
	protect_block_a: assert property (!data_write_protect_n |-> !mbus.start) // RULE6
		else $error("write started while protected");
	protect_abort_a: assert property (prot && !st.wr |=> !st.wr && st.werr) // RULE16
		else $error("protected start not refused with error");
	read_cycle_a: assert property (ctl_wr && cpu_wdata[`DFA_B_RD] && !cpu_stall && !soft_reset
		|=> st.rd && cpu_stall ##1 !st.rd) // RULE9
		else $error("read start bit not cleared after one cycle");
	read_zero_a: assert property (st.rd && !df_hit && !soft_reset |=> st.data == 14'h0000) // RULE4
		else $error("unimplemented read did not return zero");
	data_hold_a: assert property (!st.rd && !(cpu_wr && cpu_addr == `DFA_DAT_LO) && !soft_reset
		|=> $stable(st.data[7:0])) // RULE8
		else $error("data low changed without read or write");
	ind_zero_a: assert property (ind_ptr[15:12] != `DFA_IND_TAG |=> ind_rdata == 8'h00) // RULE3
		else $error("indirect read outside data flash not zero");
	wr_length_a: assert property ($fell(st.wr) && !$past(soft_reset) |-> wr_cnt == 16'(PROG_CYCLES)) // RULE26
		else $error("write start bit length differs from program time");
	wr_zero_a: assert property (st.wr && ctl_wr && !cpu_wdata[`DFA_B_WR] && !mbus.done && !soft_reset
		|=> st.wr) // RULE24
		else $error("writing zero cleared an active write");
	done_flag_a: assert property (mbus.done && !soft_reset |=> op_done_flag && !st.wr && !st.erase_en) // RULE17
		else $error("completion did not set done and clear start");
	seq_error_a: assert property (st.key == KEY_ONE && !key_wr |=> st.werr && st.key == KEY_IDLE) // RULE27
		else $error("broken unlock did not flag an error");
	werr_sticky_a: assert property (st.werr && !(reg_wr && ctl_wr && !cpu_wdata[`DFA_B_WERR]) |=> st.werr) // RULE19
		else $error("write error cleared by hardware");
	reset_err_a: assert property (st.wr && soft_reset |=> st.werr && !st.wr) // RULE18
		else $error("reset during write not flagged");
	// A write may only run when region one was selected at the start
	region_write_a: assert property ($rose(st.wr) |-> $past(st.region)) // RULE23
		else $error("write started outside the data flash region");
	enable_write_a: assert property ($rose(st.wr) |-> $past(cpu_wdata[`DFA_B_PROGRAM_ENABLE])) // RULE15
		else $error("write started without program enable");
	done_clear_a: assert property (op_done_clear && !mbus.done && !soft_reset |=> !op_done_flag) // RULE17
		else $error("done flag not cleared by firmware");
endmodule : dfa_ctrl

// [bench/dfa_cpu_model.sv]
// Firmware side model issuing register cycles to the data flash access controller
`timescale 1ns/1ps
`include "dfa_defines.svh"
module dfa_cpu_model (
	// Clock
	input  wire logic        clock,
	// Register port
	output logic      [15:0] cpu_addr,
	output logic             cpu_wr,
	output logic      [7:0]  cpu_wdata,
	input  wire logic [7:0]  cpu_rdata
);
	initial begin
		cpu_addr  = 16'h0000;
		cpu_wr    = 1'b0;
		cpu_wdata = 8'h00;
	end

	// Called just after an edge; the write is taken at the next edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cpu_addr  <= a;
		cpu_wr    <= 1'b1;
		cpu_wdata <= d;
		@(posedge clock);
	endtask : wr

	task automatic release_bus();
		cpu_wr <= 1'b0;
	endtask : release_bus

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		cpu_addr <= a;
		cpu_wr   <= 1'b0;
		#1 d = cpu_rdata;
		@(posedge clock);
	endtask : rd

	// Three back-to-back writes with no gap
	task automatic unlock(input logic [7:0] c);
		wr(`DFA_KEY, `DFA_KEY_FIRST);
		wr(`DFA_KEY, `DFA_KEY_SECOND);
		wr(`DFA_CTRL, c);
	endtask : unlock
endmodule : dfa_cpu_model

// [bench/test_data_flash_byte_access.sv]
// Self-checking bench of the data flash access controller
`timescale 1ns/1ps
`include "dfa_defines.svh"
module test_data_flash_byte_access import dfa_pkg::*;;
	localparam int PROG = 4;
	typedef struct packed {logic [7:0] off; logic [7:0] dat;} dfa_row_t;
	dfa_row_t    rows [3] = '{'{8'h00, 8'h5a}, '{8'hff, 8'ha5}, '{8'h10, 8'hff}};
	logic        clock, rstn, cpu_wr, cpu_stall, wp_n, disturb, soft_reset;
	logic        irq_en, done_clr, done_flag, done_irq;
	logic [15:0] cpu_addr, ind_ptr;
	logic [7:0]  cpu_wdata, cpu_rdata, ind_rdata, v;
	int          errors, comparisons, n;

	dfa_ctrl #(.DEPTH(256), .PROG_CYCLES(PROG)) u_dut (.clock(clock), .rstn(rstn), .cpu_addr(cpu_addr),
		.cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_stall(cpu_stall),
		.ind_ptr(ind_ptr), .ind_rdata(ind_rdata), .data_write_protect_n(wp_n), .cpu_disturb(disturb),
		.soft_reset(soft_reset), .op_done_irq_enable(irq_en), .op_done_clear(done_clr),
		.op_done_flag(done_flag), .op_done_irq(done_irq));
	dfa_cpu_model u_cpu (.clock(clock), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	// Counts stalled edges; returns 1 ns after an edge once the stall is gone
	task automatic wait_done(output int cnt);
		u_cpu.release_bus();
		cnt = 0;
		#1;
		while (cpu_stall !== 1'b0) begin
			@(posedge clock);
			cnt++;
			if (cnt > 50) begin
				errors++;
				stop_test();
			end
			#1;
		end
	endtask : wait_done

	task automatic setup(input logic [7:0] off, input logic [7:0] dat, input logic [7:0] c);
		u_cpu.wr(`DFA_ADR_LO, off);
		u_cpu.wr(`DFA_ADR_HI, `DFA_DF_PAGE);
		u_cpu.wr(`DFA_DAT_LO, dat);
		u_cpu.wr(`DFA_CTRL, c);
	endtask : setup

	task automatic rdback(input logic [7:0] off, output logic [7:0] d);
		int c;
		u_cpu.wr(`DFA_ADR_LO, off);
		u_cpu.wr(`DFA_CTRL, 8'h41);
		wait_done(c);
		chk(8'(c), 8'h01);
		@(posedge clock);
		u_cpu.rd(`DFA_CTRL, d);
		chk(d, 8'h40);
		u_cpu.rd(`DFA_DAT_LO, d);
	endtask : rdback

	initial begin
		errors = 0;
		comparisons = 0;
		rstn = 1'b0;
		ind_ptr = 16'h0000;
		wp_n = 1'b1;
		disturb = 1'b0;
		soft_reset = 1'b0;
		irq_en = 1'b0;
		done_clr = 1'b0;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		u_cpu.rd(`DFA_CTRL, v);
		chk(v, `DFA_CTRL_RST);
		chk({7'h0, done_flag}, 8'h00);
		irq_en <= 1'b1;
		foreach (rows[i]) begin
			setup(rows[i].off, rows[i].dat, 8'h44);
			u_cpu.unlock(8'h46);
			wait_done(n);
			chk(8'(n), 8'(PROG));
			chk({6'h0, done_flag, done_irq}, 8'h03);
			@(posedge clock);
			u_cpu.rd(`DFA_CTRL, v);
			chk(v, 8'h44);
			done_clr <= 1'b1;
			irq_en <= 1'b0;
			#1 chk({6'h0, done_flag, done_irq}, 8'h02);
			@(posedge clock);
			done_clr <= 1'b0;
			irq_en <= 1'b1;
			rdback(rows[i].off, v);
			chk(v, rows[i].dat);
			ind_ptr <= {`DFA_IND_TAG, 4'h0, rows[i].off};
			@(posedge clock);
			#1 chk(ind_rdata, rows[i].dat);
			chk({7'h0, done_flag}, 8'h00);
			@(posedge clock);
		end
		ind_ptr <= 16'h7f34;
		u_cpu.wr(`DFA_DAT_LO, 8'h3c);
		u_cpu.wr(`DFA_DAT_HI, 8'hff);
		u_cpu.wr(`DFA_ADR_HI, 8'hf0);
		#1 chk(ind_rdata, 8'h00);
		@(posedge clock);
		u_cpu.rd(`DFA_DAT_LO, v);
		chk(v, 8'h3c);
		u_cpu.rd(`DFA_DAT_HI, v);
		chk(v, 8'h3f);
		u_cpu.rd(`DFA_ADR_HI, v);
		chk(v, 8'hf0);
		u_cpu.wr(`DFA_CTRL, 8'h01);
		wait_done(n);
		chk(8'(n), 8'h01);
		@(posedge clock);
		u_cpu.rd(`DFA_DAT_LO, v);
		chk(v, 8'h00);
		u_cpu.rd(`DFA_KEY, v);
		chk(v, 8'h00);
		wp_n <= 1'b0;
		setup(8'h00, 8'h11, 8'h44);
		u_cpu.unlock(8'h46);
		wait_done(n);
		chk(8'(n), 8'h00);
		@(posedge clock);
		u_cpu.rd(`DFA_CTRL, v);
		chk(v, 8'h4c);
		u_cpu.wr(`DFA_CTRL, 8'h40);
		u_cpu.rd(`DFA_CTRL, v);
		chk(v, 8'h40);
		u_cpu.wr(`DFA_CTRL, 8'h48);
		u_cpu.rd(`DFA_CTRL, v);
		chk(v, 8'h48);
		wp_n <= 1'b1;
		rdback(8'h00, v);
		chk(v, 8'h5a);
		u_cpu.wr(`DFA_CTRL, 8'h44);
		u_cpu.wr(`DFA_KEY, `DFA_KEY_FIRST);
		u_cpu.release_bus();
		repeat (2) @(posedge clock);
		u_cpu.rd(`DFA_CTRL, v);
		chk(v, 8'h4c);
		u_cpu.wr(`DFA_CTRL, 8'h44);
		u_cpu.wr(`DFA_KEY, `DFA_KEY_FIRST);
		disturb <= 1'b1;
		u_cpu.wr(`DFA_KEY, `DFA_KEY_SECOND);
		disturb <= 1'b0;
		u_cpu.rd(`DFA_CTRL, v);
		chk(v, 8'h4c);
		u_cpu.wr(`DFA_CTRL, 8'h46);
		wait_done(n);
		chk(8'(n), 8'h00);
		@(posedge clock);
		setup(8'h10, 8'h22, 8'h40);
		u_cpu.unlock(8'h42);
		wait_done(n);
		chk(8'(n), 8'h00);
		@(posedge clock);
		u_cpu.rd(`DFA_CTRL, v);
		chk(v, 8'h40);
		ind_ptr <= 16'h7010;
		@(posedge clock);
		#1 chk(ind_rdata, 8'hff);
		@(posedge clock);
		setup(8'h20, 8'h33, 8'h44);
		u_cpu.unlock(8'h46);
		u_cpu.release_bus();
		@(posedge clock);
		soft_reset <= 1'b1;
		@(posedge clock);
		soft_reset <= 1'b0;
		@(posedge clock);
		#1 chk({7'h0, cpu_stall}, 8'h00);
		@(posedge clock);
		u_cpu.rd(`DFA_CTRL, v);
		chk(v, 8'h08);
		stop_test();
	end
endmodule : test_data_flash_byte_access
